//--- hw/sfod_decoder.sv
// =====================================================
// Byte buffer, flip-flop storage
module sfod_fifo
   import sfod_pkg::*;
#(
   parameter int WIDTH = FIFO_WIDTH,
   parameter int DEPTH = FIFO_DEPTH
)(
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   // All buffer state
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;  // Storage words
      logic [AW-1:0]               wp;   // Write index
      logic [AW-1:0]               rp;   // Read index
      logic [AW:0]                 cnt;  // Fill level
   } sfod_fifo_st_t;

   sfod_fifo_st_t s_r;
   sfod_fifo_st_t s_nxt;
   logic          push;
   logic          pop;

   // Honest full and empty
   assign in_ready_o  = (s_r.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (s_r.cnt != '0);
   assign out_data_o  = s_r.mem[s_r.rp];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // Next buffer state
   always_comb
   begin
      s_nxt = s_r;
      if (push)
      begin
         s_nxt.mem[s_r.wp] = in_data_i;
         s_nxt.wp          = s_r.wp + 1'b1;
      end
      if (pop)
      begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // State register
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
endmodule // sfod_fifo

// =====================================================
// Opcode decoder top
module sfod_decoder
   import sfod_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   input  wire logic       sck_i,
   input  wire logic       cs_n_i,
   input  wire logic       si_i,
   output sfod_cmd_t       cmd_o,
   output logic            cmd_valid_o,
   input  wire logic       cmd_ready_i,
   output logic [31:0]     addr_o,
   output logic            four_byte_o,
   output logic [7:0]      max_clk_mhz_o,
   output logic [7:0]      bank_reg_o,
   output logic            overrun_o
);

   // =====================================================
   // Link side, clocked by the serial clock
   typedef struct packed {
      logic [2:0] bit_cnt;    // Bit within byte
      logic [6:0] shift;      // Bits gathered so far
      logic       first;      // Byte is first of frame
      logic [7:0] hold;       // Last whole byte
      logic       hold_first; // Its frame-start flag
      logic       tgl;        // Flips once per byte
   } sfod_link_st_t;

   sfod_link_st_t ls_r;
   sfod_link_st_t ls_nxt;
   logic          frame_new_r; // Set while select is high

   // Frame start marker, set by reset or deselect, cleared by first clock edge
   always_ff @(posedge sck_i or posedge cs_n_i or posedge rst_i)
   begin
      if (rst_i)
         frame_new_r <= 1'b1;
      else if (cs_n_i)
         frame_new_r <= 1'b1;
      else
         frame_new_r <= 1'b0;
   end

   // Shift in bits, most significant first
   always_comb
   begin
      logic [2:0] cnt;
      logic [6:0] sh;
      logic       fst;
      cnt    = frame_new_r ? 3'h0 : ls_r.bit_cnt;
      sh     = frame_new_r ? 7'h00 : ls_r.shift;
      fst    = frame_new_r ? 1'b1 : ls_r.first;
      ls_nxt = ls_r;
      if (cnt == LAST_BIT)
      begin
         // Whole byte: publish and flip the toggle
         ls_nxt.hold       = {sh, si_i};
         ls_nxt.hold_first = fst;
         ls_nxt.tgl        = ~ls_r.tgl;
         ls_nxt.first      = 1'b0;
         ls_nxt.bit_cnt    = 3'h0;
         ls_nxt.shift      = 7'h00;
      end
      else
      begin
         ls_nxt.shift   = {sh[5:0], si_i};
         ls_nxt.bit_cnt = cnt + 3'h1;
         ls_nxt.first   = fst;
      end
   end

   // Link register; the toggle must not be cleared by select
   always_ff @(posedge sck_i or posedge rst_i)
   begin
      if (rst_i)
         ls_r <= '0;
      else
         ls_r <= ls_nxt;
   end

   // =====================================================
   // System side state
   typedef struct packed {
      logic        t1;      // Toggle sync, first stage
      logic        t2;      // Toggle sync, second stage
      logic        t3;      // Previous synced toggle
      logic        pend;    // Byte waiting for buffer
      logic [8:0]  pdata;   // Frame flag and byte
      logic        overrun; // Byte lost, sticky
      sfod_state_t st;      // Decoder state
      sfod_cmd_t   op;      // Command in progress
      logic [2:0]  need;    // Bytes still expected
      logic        four;    // Four-byte address form
      logic [7:0]  mhz;     // Clock limit of command
      logic [31:0] addr;    // Address or data gathered
      logic [7:0]  bank;    // Bank register
      logic        cv;      // Command presented
   } sfod_sys_st_t;

   sfod_sys_st_t s_r;
   sfod_sys_st_t s_nxt;
   logic         f_in_ready;
   logic         f_out_valid;
   logic [8:0]   f_out_data;
   logic         pop;
   logic         byte_ev;

   // Crossing: hold is stable for eight link clocks after the toggle
   assign byte_ev = s_r.t2 ^ s_r.t3;
   assign pop     = f_out_valid && !s_r.cv;

   sfod_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (s_r.pend),
      .in_ready_o  (f_in_ready),
      .in_data_i   (s_r.pdata),
      .out_valid_o (f_out_valid),
      .out_ready_i (!s_r.cv),
      .out_data_o  (f_out_data)
   );

   // Decode, gather address bytes, present command
   always_comb
   begin
      sfod_cmd_t  dc_cmd;
      logic [2:0] dc_need;
      logic       dc_four;
      logic [7:0] dc_mhz;
      logic [7:0] byte_in;
      logic [31:0] sh;
      byte_in = f_out_data[7:0];
      sh      = {s_r.addr[23:0], byte_in};
      dc_cmd  = CMD_UNKNOWN;
      dc_need = BYTES_NONE;
      dc_four = 1'b0;
      dc_mhz  = MHZ_133;
      s_nxt   = s_r;
      s_nxt.t1 = ls_r.tgl;
      s_nxt.t2 = s_r.t1;
      s_nxt.t3 = s_r.t2;

      // Opcode table
      unique case (byte_in)
         OP_LEGACY_SIGNATURE_READ:        dc_cmd = CMD_LEGACY_SIGNATURE_READ;
         OP_IDENTIFICATION_READ:          dc_cmd = CMD_IDENTIFICATION_READ;
         OP_STATUS_CONFIG_WRITE:          dc_cmd = CMD_STATUS_CONFIG_WRITE;
         OP_FAIL_FLAGS_CLEAR:             dc_cmd = CMD_FAIL_FLAGS_CLEAR;
         OP_ECC_STATUS_READ:
         begin
            dc_cmd  = CMD_ECC_STATUS_READ;
            dc_need = ADDR_BYTES_LONG;
            dc_four = 1'b1;
         end
         OP_BANK_REG_READ:                dc_cmd = CMD_BANK_REG_READ;
         OP_BANK_REG_WRITE:
         begin
            dc_cmd  = CMD_BANK_REG_WRITE;
            dc_need = DATA_BYTES_BANK;
         end
         OP_BANK_REG_LEGACY_ACCESS:
         begin
            dc_cmd  = CMD_BANK_REG_LEGACY_ACCESS;
            dc_need = DATA_BYTES_BANK;
         end
         OP_LEARNING_PATTERN_READ:        dc_cmd = CMD_LEARNING_PATTERN_READ;
         OP_LEARNING_PATTERN_NV_PROGRAM:  dc_cmd = CMD_LEARNING_PATTERN_NV_PROGRAM;
         OP_LEARNING_PATTERN_VOLATILE_WR: dc_cmd = CMD_LEARNING_PATTERN_VOLATILE_WRITE;
         OP_NORMAL_READ:
         begin
            dc_cmd  = CMD_NORMAL_READ;
            dc_four = s_r.bank[ADDR_LEN_BIT];
            dc_need = dc_four ? ADDR_BYTES_LONG : ADDR_BYTES_SHORT;
            dc_mhz  = MHZ_50;
         end
         OP_NORMAL_READ_LONG_ADDR:
         begin
            dc_cmd  = CMD_NORMAL_READ_LONG_ADDR;
            dc_four = 1'b1;
            dc_need = ADDR_BYTES_LONG;
            dc_mhz  = MHZ_50;
         end
         OP_FAST_READ:
         begin
            dc_cmd  = CMD_FAST_READ;
            dc_four = s_r.bank[ADDR_LEN_BIT];
            dc_need = dc_four ? ADDR_BYTES_LONG : ADDR_BYTES_SHORT;
         end
         OP_FAST_READ_LONG_ADDR:
         begin
            dc_cmd  = CMD_FAST_READ_LONG_ADDR;
            dc_four = 1'b1;
            dc_need = ADDR_BYTES_LONG;
         end
         // double rate read at 80 MHz
         OP_DOUBLE_RATE_FAST_READ:
         begin
            dc_cmd  = CMD_DOUBLE_RATE_FAST_READ;
            dc_four = s_r.bank[ADDR_LEN_BIT];
            dc_need = dc_four ? ADDR_BYTES_LONG : ADDR_BYTES_SHORT;
            dc_mhz  = MHZ_80;
         end
         default:                         dc_mhz = MHZ_NONE;
      endcase

      // Capture stage; a new byte overwrites a waiting one, which is lost if the buffer is full
      if (s_r.pend && f_in_ready)
         s_nxt.pend = 1'b0;
      if (byte_ev)
      begin
         if (s_r.pend && !f_in_ready)
            s_nxt.overrun = 1'b1;
         s_nxt.pend  = 1'b1;
         s_nxt.pdata = {ls_r.hold_first, ls_r.hold};
      end

      // Downstream takes the command
      if (s_r.cv && cmd_ready_i)
         s_nxt.cv = 1'b0;

      if (pop)
      begin
         if (f_out_data[8])
         begin
            // Frame start: new opcode aborts any partial command
            s_nxt.op   = dc_cmd;
            s_nxt.need = dc_need;
            s_nxt.four = dc_four;
            s_nxt.mhz  = dc_mhz;
            s_nxt.addr = '0;
            if (dc_need == BYTES_NONE)
            begin
               s_nxt.cv = 1'b1;
               s_nxt.st = ST_SKIP;
            end
            else
               s_nxt.st = ST_COLLECT;
         end
         else
         begin
            unique case (s_r.st)
               ST_COLLECT:
               begin
                  s_nxt.addr = sh;
                  s_nxt.need = s_r.need - 3'h1;
                  if (s_r.need == DATA_BYTES_BANK)
                  begin
                     s_nxt.cv = 1'b1;
                     s_nxt.st = ST_SKIP;
                     if (s_r.op == CMD_BANK_REG_WRITE || s_r.op == CMD_BANK_REG_LEGACY_ACCESS)
                     begin
                        s_nxt.bank = byte_in;
                        s_nxt.addr = {24'h000000, byte_in};
                     end
                     else if (!s_r.four)
                     begin
                        s_nxt.addr = {{(8-BANK_SEL_W){1'b0}}, s_r.bank[BANK_SEL_W-1:0], sh[23:0]};
                     end
                  end
               end
               ST_SKIP:    s_nxt.st = ST_SKIP;
               ST_IDLE:    s_nxt.st = ST_IDLE;
               default:    s_nxt.st = ST_IDLE;
            endcase
         end
      end
   end

   // System register
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         s_r      <= '0;
         s_r.st   <= ST_IDLE;
         s_r.op   <= CMD_NONE;
         s_r.bank <= BANK_RESET;
      end
      else
         s_r <= s_nxt;
   end

   // Outputs straight from registers
   assign cmd_o         = s_r.op;
   assign cmd_valid_o   = s_r.cv;
   assign addr_o        = s_r.addr;
   assign four_byte_o   = s_r.four;
   assign max_clk_mhz_o = s_r.mhz;
   assign bank_reg_o    = s_r.bank;
   assign overrun_o     = s_r.overrun;

   // =====================================================
   // Checks
   bank_window_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $rose(cmd_valid_o) && !four_byte_o && cmd_o inside {CMD_NORMAL_READ, CMD_FAST_READ}
      |-> addr_o[31:24] == {{(8-BANK_SEL_W){1'b0}}, bank_reg_o[BANK_SEL_W-1:0]})
      else $error("short address not placed in bank window");

   id_decode_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      pop && f_out_data == {1'b1, OP_IDENTIFICATION_READ}
      |=> cmd_valid_o && cmd_o == CMD_IDENTIFICATION_READ && max_clk_mhz_o == MHZ_133)
      else $error("identification read not presented");

   reg_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      pop && f_out_data == {1'b1, OP_STATUS_CONFIG_WRITE}
      |=> cmd_valid_o && cmd_o == CMD_STATUS_CONFIG_WRITE)
      else $error("status write not presented");

   ecc_long_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cmd_valid_o && cmd_o == CMD_ECC_STATUS_READ |-> four_byte_o)
      else $error("ecc read without long address");

   bank_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $rose(cmd_valid_o) && cmd_o inside {CMD_BANK_REG_WRITE, CMD_BANK_REG_LEGACY_ACCESS}
      |-> bank_reg_o == addr_o[7:0])
      else $error("bank register not written");

   bank_stable_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ##1 $changed(bank_reg_o)
      |-> $rose(cmd_valid_o) && cmd_o inside {CMD_BANK_REG_WRITE, CMD_BANK_REG_LEGACY_ACCESS})
      else $error("bank register changed outside a write");

   len_select_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      pop && f_out_data == {1'b1, OP_NORMAL_READ}
      |=> four_byte_o == $past(bank_reg_o[ADDR_LEN_BIT]) && max_clk_mhz_o == MHZ_50)
      else $error("address length not taken from bank bit");

   fast_long_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $rose(cmd_valid_o) && cmd_o == CMD_FAST_READ_LONG_ADDR |-> four_byte_o && max_clk_mhz_o == MHZ_133)
      else $error("fast long read misdecoded");

   cmd_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_o) && $stable(addr_o))
      else $error("command dropped while stalled");

endmodule // sfod_decoder

//--- include/sfod_pkg.sv
// Function
// - Bank 00 and 01 map to 16 MB windows
// - 90h legacy signature read, host at most 133 MHz
// - 9Fh identification read up to 133 MHz
// - 01h status and configuration write, 133 MHz
// - 30h clears erase and program fail flags
// - 18h ecc status read, always four address bytes
// - 16h bank read, 17h and B9h bank write
// - 41h learning pattern read up to 133 MHz
// - 43h programs nonvolatile learning pattern copy
// - 4Ah writes volatile learning pattern register
// - 03h and 13h normal reads, host 50 MHz
// - 0Bh and 0Ch fast reads up to 133 MHz
// - 0Dh double rate read, host 80 MHz
// - Address length bit 7 cleared at reset
// - Bank register supplies high address byte
// - Reads stream on, bank register left unchanged
package sfod_pkg;

   // =====================================================
   // Opcodes
   localparam logic [7:0] OP_LEGACY_SIGNATURE_READ        = 8'h90;
   localparam logic [7:0] OP_IDENTIFICATION_READ          = 8'h9F;
   localparam logic [7:0] OP_STATUS_CONFIG_WRITE          = 8'h01;
   localparam logic [7:0] OP_FAIL_FLAGS_CLEAR             = 8'h30;
   localparam logic [7:0] OP_ECC_STATUS_READ              = 8'h18;
   localparam logic [7:0] OP_BANK_REG_READ                = 8'h16;
   localparam logic [7:0] OP_BANK_REG_WRITE               = 8'h17;
   localparam logic [7:0] OP_BANK_REG_LEGACY_ACCESS       = 8'hB9;
   localparam logic [7:0] OP_LEARNING_PATTERN_READ        = 8'h41;
   localparam logic [7:0] OP_LEARNING_PATTERN_NV_PROGRAM  = 8'h43;
   localparam logic [7:0] OP_LEARNING_PATTERN_VOLATILE_WR = 8'h4A;
   localparam logic [7:0] OP_NORMAL_READ                  = 8'h03;
   localparam logic [7:0] OP_NORMAL_READ_LONG_ADDR        = 8'h13;
   localparam logic [7:0] OP_FAST_READ                    = 8'h0B;
   localparam logic [7:0] OP_FAST_READ_LONG_ADDR          = 8'h0C;
   localparam logic [7:0] OP_DOUBLE_RATE_FAST_READ        = 8'h0D;

   // =====================================================
   // Highest serial clock per command, in MHz
   localparam logic [7:0] MHZ_133 = 8'h85;  // 133 MHz
   localparam logic [7:0] MHZ_80  = 8'h50;  // 80 MHz
   localparam logic [7:0] MHZ_50  = 8'h32;  // 50 MHz
   localparam logic [7:0] MHZ_NONE = 8'h00; // Unknown opcode

   // =====================================================
   // Bank register layout
   localparam logic [7:0] BANK_RESET    = 8'h00; // Bank 0, three-byte addressing
   localparam int         ADDR_LEN_BIT  = 7;     // address_length_select
   localparam int         BANK_SEL_W    = 2;     // Bank select bits 1:0
   localparam logic [2:0] ADDR_BYTES_SHORT = 3'h3;
   localparam logic [2:0] ADDR_BYTES_LONG  = 3'h4;
   localparam logic [2:0] DATA_BYTES_BANK  = 3'h1;
   localparam logic [2:0] BYTES_NONE       = 3'h0;
   localparam logic [2:0] LAST_BIT         = 3'h7;

   // =====================================================
   // Byte buffer geometry: frame-start flag plus byte
   localparam int FIFO_WIDTH = 9;
   localparam int FIFO_DEPTH = 16;

   // Decoded commands
   typedef enum logic [4:0] {
      CMD_NONE, CMD_LEGACY_SIGNATURE_READ, CMD_IDENTIFICATION_READ, CMD_STATUS_CONFIG_WRITE,
      CMD_FAIL_FLAGS_CLEAR, CMD_ECC_STATUS_READ, CMD_BANK_REG_READ, CMD_BANK_REG_WRITE,
      CMD_BANK_REG_LEGACY_ACCESS, CMD_LEARNING_PATTERN_READ, CMD_LEARNING_PATTERN_NV_PROGRAM,
      CMD_LEARNING_PATTERN_VOLATILE_WRITE, CMD_NORMAL_READ, CMD_NORMAL_READ_LONG_ADDR,
      CMD_FAST_READ, CMD_FAST_READ_LONG_ADDR, CMD_DOUBLE_RATE_FAST_READ, CMD_UNKNOWN
   } sfod_cmd_t;

   // Decoder states
   typedef enum logic [1:0] {ST_IDLE, ST_COLLECT, ST_SKIP} sfod_state_t;

endpackage

//--- verif/sfod_host_model.sv
// =====================================================
// Host controller: drives select, clock and data
module sfod_host_model
(
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle: clock still, device deselected
   initial
   begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end

   // One frame, MSB first, clock runs only inside
   // Clock period 64 ns, below every limit
   task automatic send(input logic [7:0] b[$], input int nb);
      int i;
      #13;
      cs_n_o = 1'b0;
      for (i = 0; i < nb; i++)
      begin
         si_o = b[i/8][7-(i%8)];
         #32 sck_o = 1'b1;
         #32 sck_o = 1'b0;
      end
      #32 cs_n_o = 1'b1;
      // Released line shows the inverse value
      si_o = ~si_o;
   endtask
endmodule // sfod_host_model

//--- verif/tb_spi_flash_opcode_decoder.sv
// =====================================================
// Testbench for the opcode decoder
module tb_spi_flash_opcode_decoder
   import sfod_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      sfod_cmd_t   c;
      logic [31:0] a;
      logic        f;
      logic [7:0]  m;
   } sfod_exp_t;

   logic        sys_clk, rst_i, cmd_ready_i, cmd_valid_o, four_byte_o, overrun_o;
   logic        sck, cs_n, si, hold, skip;
   sfod_cmd_t   cmd_o;
   logic [31:0] addr_o, ra;
   logic [7:0]  max_clk_mhz_o, bank_reg_o;
   sfod_exp_t   q[$];                 // Expected commands, oldest first
   sfod_exp_t   e;
   int          error_cnt, num_checks, seed, k;

   // Opcode tables for the loops
   logic [7:0] no_op[9] = '{8'h90, 8'h9F, 8'h01, 8'h30, 8'h16, 8'h41, 8'h43, 8'h4A, 8'hFF};
   sfod_cmd_t  no_c[9] = '{CMD_LEGACY_SIGNATURE_READ, CMD_IDENTIFICATION_READ,
      CMD_STATUS_CONFIG_WRITE, CMD_FAIL_FLAGS_CLEAR, CMD_BANK_REG_READ, CMD_LEARNING_PATTERN_READ,
      CMD_LEARNING_PATTERN_NV_PROGRAM, CMD_LEARNING_PATTERN_VOLATILE_WRITE, CMD_UNKNOWN};
   logic [7:0] rd_op[6] = '{8'h03, 8'h0B, 8'h0D, 8'h13, 8'h0C, 8'h18};
   sfod_cmd_t  rd_c[6] = '{CMD_NORMAL_READ, CMD_FAST_READ, CMD_DOUBLE_RATE_FAST_READ,
      CMD_NORMAL_READ_LONG_ADDR, CMD_FAST_READ_LONG_ADDR, CMD_ECC_STATUS_READ};
   logic [7:0] rd_m[6] = '{8'h32, 8'h85, 8'h50, 8'h32, 8'h85, 8'h85};

   sfod_host_model i_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si));

   sfod_decoder i_dut (
      .sys_clk_i(sys_clk), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
      .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i), .addr_o(addr_o),
      .four_byte_o(four_byte_o), .max_clk_mhz_o(max_clk_mhz_o), .bank_reg_o(bank_reg_o),
      .overrun_o(overrun_o));

   // System clock, 20 ns
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Random stalls on the command port
   always @(posedge sys_clk)
      #2 cmd_ready_i <= hold ? 1'b0 : (($random(seed) & 3) != 0);

   // Compare one value, count it
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask

   // Monitor: each accepted command against the oldest note
   always @(posedge sys_clk)
      if (!rst_i && !skip && cmd_valid_o === 1'b1 && cmd_ready_i === 1'b1)
      begin
         e = (q.size() != 0) ? q.pop_front() : '0;
         chk("cmd_o", 32'(e.c), 32'(cmd_o));
         chk("addr_o", e.a, addr_o);
         chk("four_byte_o", 32'(e.f), 32'(four_byte_o));
         chk("max_clk_mhz_o", 32'(e.m), 32'(max_clk_mhz_o));
      end

   // Send a frame, then wait for the notes to drain
   task automatic frame(input logic [7:0] b[$]);
      i_host.send(b, b.size() * 8);
      for (k = 0; k < 400 && q.size() != 0; k++)
         @(posedge sys_clk);
      chk("pending_notes", 32'h0, 32'(q.size()));
   endtask

   task automatic do_reset();
      @(posedge sys_clk);
      #2 rst_i = 1'b1;
      repeat (5) @(posedge sys_clk);
      #2 rst_i = 1'b0;
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Watchdog against a hang
   initial
   begin
      #1_000_000;
      error_cnt++;
      $display("[FAIL] watchdog expected finish seen hang");
      print_verdict();
   end

   // Main sequence
   initial
   begin
      seed = 32'h60CBD021;
      error_cnt = 0;
      num_checks = 0;
      hold = 1'b0;
      skip = 1'b0;
      cmd_ready_i = 1'b0;
      // Low first, so every asynchronous reset sees a rising edge
      rst_i = 1'b0;
      #1 rst_i = 1'b1;
      repeat (5) @(posedge sys_clk);
      #2 rst_i = 1'b0;
      chk("bank_reg_o", 32'h0, 32'(bank_reg_o));
      // Commands without address, extra payload ignored
      for (int i = 0; i < 9; i++)
      begin
         q.push_back('{no_c[i], 32'h0, 1'b0, (i == 8) ? 8'h00 : 8'h85});
         frame('{no_op[i], 8'hA5});
      end
      $display("test no_address done");
      // Bank write, then short reads in bank 1 and long-address reads
      q.push_back('{CMD_BANK_REG_WRITE, 32'h01, 1'b0, 8'h85});
      frame('{8'h17, 8'h01});
      chk("bank_reg_o", 32'h01, 32'(bank_reg_o));
      for (int i = 0; i < 6; i++)
      begin
         ra = $random(seed);
         if (i < 3)
            ra[31:24] = 8'h01;
         q.push_back('{rd_c[i], ra, i >= 3, rd_m[i]});
         if (i < 3)
            frame('{rd_op[i], ra[23:16], ra[15:8], ra[7:0], 8'h5A, 8'hC3});
         else
            frame('{rd_op[i], ra[31:24], ra[23:16], ra[15:8], ra[7:0], 8'h5A});
      end
      chk("bank_reg_o", 32'h01, 32'(bank_reg_o));
      $display("test reads done");
      // Legacy bank access sets four-byte mode
      q.push_back('{CMD_BANK_REG_LEGACY_ACCESS, 32'h80, 1'b0, 8'h85});
      frame('{8'hB9, 8'h80});
      chk("bank_reg_o", 32'h80, 32'(bank_reg_o));
      q.push_back('{CMD_NORMAL_READ, 32'h02345678, 1'b1, 8'h32});
      frame('{8'h03, 8'h02, 8'h34, 8'h56, 8'h78});
      // Aborted frame gives nothing, next one works
      frame('{8'h0B, 8'h11});
      q.push_back('{CMD_IDENTIFICATION_READ, 32'h0, 1'b0, 8'h85});
      frame('{8'h9F});
      $display("test bank_and_abort done");
      // Stall until the buffer overflows
      hold = 1'b1;
      skip = 1'b1;
      for (int i = 0; i < 20; i++)
         i_host.send('{8'h9F}, 8);
      repeat (10) @(posedge sys_clk);
      chk("overrun_o", 32'h1, 32'(overrun_o));
      chk("cmd_valid_o", 32'h1, 32'(cmd_valid_o));
      do_reset();
      hold = 1'b0;
      skip = 1'b0;
      chk("overrun_o", 32'h0, 32'(overrun_o));
      chk("bank_reg_o", 32'h0, 32'(bank_reg_o));
      chk("cmd_valid_o", 32'h0, 32'(cmd_valid_o));
      q.push_back('{CMD_NORMAL_READ, 32'h00ABCDEF, 1'b0, 8'h32});
      frame('{8'h03, 8'hAB, 8'hCD, 8'hEF});
      $display("test overrun_reset done");
      print_verdict();
   end
endmodule // tb_spi_flash_opcode_decoder
